// ==== logic/supply_limit_command_bank.sv ====
// How it works
// - Paged slew rate word at 0x27, reset 0xAA00
// - Shared switching frequency word 0x33, reset 0xFB52
// - Start/stop input thresholds gate conversion with hysteresis
// - Paged current sense gain 0x38, reset 0xAA8F
// - Paged output overvoltage fault/warn limits 0x40/0x42
// - Paged overvoltage action byte 0x41, reset 0xB8
// - Paged undervoltage warn/fault limits 0x43/0x44
// - Paged undervoltage action byte 0x45, reset 0xB8
// - Paged overcurrent fault/warn limits 0x46/0x4A
// - Paged overcurrent action byte 0x47, reset 0x00
// - Paged hot fault/warn limits 0x4F/0x51
// - Paged hot action byte 0x50, reset 0xB8
// - Paged cold limit 0x53, action 0x54
// - Shared input overvoltage limit 0x55, action 0x56
// - Shared input undervoltage warn limit 0x58
// - Shared input overcurrent warn limit 0x5D
// - Turn-on delay in ms before rail on
// - Page byte 0x00 selects channel copy
// - Output voltage words are unsigned times 2^-12
// - Unsupported command code raises command fault
`timescale 1ns/10ps
module supply_limit_command_bank
   import supply_limit_pkg::*;
#(
   parameter int TICK_CYCLES = MS_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_cmd_req,
   input wire logic i_cmd_write,
   input wire logic [7:0] i_cmd_code,
   input wire logic [15:0] i_cmd_wdata,
   input wire logic [CHANNELS-1:0] i_enable,
   input wire logic [15:0] i_vin_linear,
   input wire logic [CHANNELS-1:0][15:0] i_vout_linear,
   output logic [15:0] o_rdata,
   output logic o_rvalid,
   output logic o_cmd_fault,
   output logic o_input_ok,
   output logic [CHANNELS-1:0] o_rail_on,
   output logic [CHANNELS-1:0] o_vout_ov_fault,
   output logic [CHANNELS-1:0] o_vout_uv_fault
);

   // Linear word to signed fixed point with 16 fraction bits
   // Limitation: large positive exponents overflow 32 bits, so keep limits in a sane range
   function automatic logic signed [31:0] linear_to_fixed(input logic [15:0] v);
      logic signed [31:0] mant;
      logic [4:0] sh;
      mant = {{21{v[10]}}, v[10:0]};
      // Exponent plus 16 in five bits is the exponent with its top bit flipped
      sh = {~v[15], v[14:11]};
      return mant <<< sh;
   endfunction : linear_to_fixed

   state_t st_reg; // Registered state
   state_t st_next; // Next state
   logic paged_hit; // Code names a per-channel register
   logic shared_hit; // Code names a shared register
   logic [4:0] paged_idx; // Matching per-channel slot
   logic [2:0] shared_idx; // Matching shared slot
   logic page_ok; // Page selector holds a legal value
   logic [0:0] rd_ch; // Channel used for reads
   logic code_hit; // Code is served by this bank
   logic signed [31:0] vin_fixed; // Input voltage, fixed point
   logic signed [31:0] start_fixed; // Start threshold, fixed point
   logic signed [31:0] stop_fixed; // Stop threshold, fixed point

   // Command decode against the code tables
   always_comb begin
      paged_hit = 1'b0;
      shared_hit = 1'b0;
      paged_idx = '0;
      shared_idx = '0;
      for (int k = 0; k < PAGED_N; k++) begin
         if (i_cmd_code == PAGED_CODE[k]) begin
            paged_hit = 1'b1;
            paged_idx = 5'(k);
         end
      end
      for (int k = 0; k < SHARED_N; k++) begin
         if (i_cmd_code == SHARED_CODE[k]) begin
            shared_hit = 1'b1;
            shared_idx = 3'(k);
         end
      end
   end

   // Broadcast page reads back channel 0
   assign page_ok = (st_reg.page < 8'(CHANNELS)) || (st_reg.page == PAGE_ALL);
   assign rd_ch = (st_reg.page == PAGE_ALL) ? 1'b0 : st_reg.page[0];
   assign code_hit = (i_cmd_code == CODE_PAGE) || shared_hit || (paged_hit && page_ok);
   assign vin_fixed = linear_to_fixed(i_vin_linear);
   assign start_fixed = linear_to_fixed(st_reg.shared[SHARED_START]);
   assign stop_fixed = linear_to_fixed(st_reg.shared[SHARED_STOP]);

   // Next-state logic: command port, thresholds, turn-on sequencing
   always_comb begin
      logic signed [31:0] dly_fixed;
      logic [15:0] dly_ms;
      logic tick;
      logic go;
      dly_fixed = '0;
      dly_ms = '0;
      tick = 1'b0;
      go = 1'b0;
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      st_next.fault = 1'b0;

      // Enable pins pass two flops before use
      st_next.en_meta = i_enable;
      st_next.en_sync = st_reg.en_meta;

      if (i_cmd_req) begin
         // Any code outside the bank, or paged access with a bad page
         st_next.fault = !code_hit;
         if (i_cmd_write) begin
            if (i_cmd_code == CODE_PAGE) begin
               // Only real channels or broadcast are accepted
               if ((i_cmd_wdata[7:0] < 8'(CHANNELS)) || (i_cmd_wdata[7:0] == PAGE_ALL)) begin
                  st_next.page = i_cmd_wdata[7:0];
               end else begin
                  st_next.fault = 1'b1;
               end
            end else if (shared_hit) begin
               // Byte registers keep their upper half at zero
               st_next.shared[shared_idx] = SHARED_IS_BYTE[shared_idx] ?
                  {8'h00, i_cmd_wdata[7:0]} : i_cmd_wdata;
            end else if (paged_hit && page_ok) begin
               for (int c = 0; c < CHANNELS; c++) begin
                  if ((st_reg.page == PAGE_ALL) || (st_reg.page == 8'(c))) begin
                     st_next.paged[c][paged_idx] = PAGED_IS_BYTE[paged_idx] ?
                        {8'h00, i_cmd_wdata[7:0]} : i_cmd_wdata;
                  end
               end
            end
         end else begin
            // Reads answer one cycle later; unsupported codes read zero
            st_next.rvalid = 1'b1;
            if (i_cmd_code == CODE_PAGE) begin
               st_next.rdata = {8'h00, st_reg.page};
            end else if (shared_hit) begin
               st_next.rdata = st_reg.shared[shared_idx];
            end else if (paged_hit && page_ok) begin
               st_next.rdata = st_reg.paged[rd_ch][paged_idx];
            end else begin
               st_next.rdata = 16'h0000;
            end
         end
      end

      // Input window with hysteresis: on at start, off at stop
      if (vin_fixed >= start_fixed) begin
         st_next.input_ok = 1'b1;
      end else if (vin_fixed <= stop_fixed) begin
         st_next.input_ok = 1'b0;
      end

      // Free-running millisecond tick for the turn-on delay
      if (st_reg.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
         st_next.tick_cnt = '0;
         tick = 1'b1;
      end else begin
         st_next.tick_cnt = st_reg.tick_cnt + 32'h0000_0001;
      end

      for (int c = 0; c < CHANNELS; c++) begin
         // Fraction of a ms is dropped; negative delay acts as zero
         dly_fixed = linear_to_fixed(st_reg.paged[c][SLOT_TURN_ON_DELAY]);
         dly_ms = dly_fixed[31] ? 16'h0000 : dly_fixed[31:16];
         go = st_reg.en_sync[c] && st_reg.input_ok;
         if (!go) begin
            st_next.rail_on[c] = 1'b0;
            st_next.delay_cnt[c] = '0;
         end else if (!st_reg.rail_on[c]) begin
            if (st_reg.delay_cnt[c] >= dly_ms) begin
               st_next.rail_on[c] = 1'b1;
            end else if (tick) begin
               st_next.delay_cnt[c] = st_reg.delay_cnt[c] + 16'h0001;
            end
         end
         // Output voltage words compare as plain unsigned counts
         st_next.ov_flag[c] = i_vout_linear[c] > st_reg.paged[c][SLOT_OV_FAULT];
         st_next.uv_flag[c] = i_vout_linear[c] < st_reg.paged[c][SLOT_UV_FAULT];
      end
   end

   // State register; reset loads every documented default
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg.page <= PAGE_RESET;
         st_reg.paged <= {CHANNELS{PAGED_RESET}};
         st_reg.shared <= SHARED_RESET;
         st_reg.rdata <= '0;
         st_reg.rvalid <= 1'b0;
         st_reg.fault <= 1'b0;
         st_reg.input_ok <= 1'b0;
         st_reg.tick_cnt <= '0;
         st_reg.delay_cnt <= '0;
         st_reg.rail_on <= '0;
         st_reg.en_meta <= '0;
         st_reg.en_sync <= '0;
         st_reg.ov_flag <= '0;
         st_reg.uv_flag <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign o_rdata = st_reg.rdata;
   assign o_rvalid = st_reg.rvalid;
   assign o_cmd_fault = st_reg.fault;
   assign o_input_ok = st_reg.input_ok;
   assign o_rail_on = st_reg.rail_on;
   assign o_vout_ov_fault = st_reg.ov_flag;
   assign o_vout_uv_fault = st_reg.uv_flag;

   // Every read answers on the next edge
   property p_read_answers;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && !i_cmd_write |=> o_rvalid;
   endproperty
   a_read_answers: assert property (p_read_answers) else $error("read not answered");

   // Unknown codes flag the command fault
   property p_bad_code_fault;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && !code_hit |=> o_cmd_fault;
   endproperty
   a_bad_code_fault: assert property (p_bad_code_fault) else $error("no fault on bad code");

   // Shared supported code never faults
   property p_shared_no_fault;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && shared_hit |=> !o_cmd_fault;
   endproperty
   a_shared_no_fault: assert property (p_shared_no_fault) else $error("fault on good code");

   // Legal page write lands in the selector
   property p_page_write;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && i_cmd_write && i_cmd_code == CODE_PAGE && i_cmd_wdata[7:0] == 8'h01
      |=> st_reg.page == 8'h01;
   endproperty
   a_page_write: assert property (p_page_write) else $error("page not taken");

   // Frequency read returns the stored word
   property p_freq_read;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && !i_cmd_write && i_cmd_code == SHARED_CODE[SHARED_FREQ] |=> o_rdata == $past(st_reg.shared[SHARED_FREQ]);
   endproperty
   a_freq_read: assert property (p_freq_read) else $error("frequency readback wrong");

   // Paged action bytes read with a zero upper half
   property p_byte_read;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && !i_cmd_write && paged_hit && page_ok && PAGED_IS_BYTE[paged_idx] |=> o_rdata[15:8] == 8'h00;
   endproperty
   a_byte_read: assert property (p_byte_read) else $error("action byte upper half set");

   // Without the synced enable the rail is off
   property p_rail_needs_enable;
      @(posedge i_clk) disable iff (!i_nrst)
      !st_reg.en_sync[0] |=> !o_rail_on[0];
   endproperty
   a_rail_needs_enable: assert property (p_rail_needs_enable) else $error("rail on while disabled");

   // Rail turns on only after enable and input were good
   property p_rail_rise_cause;
      @(posedge i_clk) disable iff (!i_nrst)
      $rose(o_rail_on[0]) |-> $past(st_reg.en_sync[0]) && $past(st_reg.input_ok);
   endproperty
   a_rail_rise_cause: assert property (p_rail_rise_cause) else $error("rail on without cause");

   // Input at or below the stop level halts conversion
   property p_input_stop;
      @(posedge i_clk) disable iff (!i_nrst)
      vin_fixed <= stop_fixed && vin_fixed < start_fixed |=> !o_input_ok;
   endproperty
   a_input_stop: assert property (p_input_stop) else $error("input window not closed");

   // Overvoltage compare follows the limit as unsigned
   property p_ov_compare;
      @(posedge i_clk) disable iff (!i_nrst)
      i_vout_linear[0] > st_reg.paged[0][SLOT_OV_FAULT] |=> o_vout_ov_fault[0];
   endproperty
   a_ov_compare: assert property (p_ov_compare) else $error("overvoltage not flagged");

   // A read answer never appears without a read the cycle before
   property p_rvalid_pulse;
      @(posedge i_clk) disable iff (!i_nrst)
      !(i_cmd_req && !i_cmd_write) |=> !o_rvalid;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer without read");

   // The fault flag is a one-cycle pulse tied to a command
   property p_fault_pulse;
      @(posedge i_clk) disable iff (!i_nrst)
      !i_cmd_req |=> !o_cmd_fault;
   endproperty
   a_fault_pulse: assert property (p_fault_pulse) else $error("fault without command");

   // Out-of-range page is refused and the old page kept
   property p_bad_page;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && i_cmd_write && i_cmd_code == CODE_PAGE && i_cmd_wdata[7:0] >= 8'(CHANNELS) &&
      i_cmd_wdata[7:0] != PAGE_ALL |=> o_cmd_fault && st_reg.page == $past(st_reg.page);
   endproperty
   a_bad_page: assert property (p_bad_page) else $error("bad page accepted");

   // Shared word write lands in its slot whole
   property p_shared_write;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && i_cmd_write && shared_hit && !SHARED_IS_BYTE[shared_idx]
      |=> st_reg.shared[$past(shared_idx)] == $past(i_cmd_wdata);
   endproperty
   a_shared_write: assert property (p_shared_write) else $error("shared write lost");

   // Paged word write lands in the selected channel's copy
   property p_paged_write;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && i_cmd_write && paged_hit && page_ok && !PAGED_IS_BYTE[paged_idx]
      |=> st_reg.paged[$past(rd_ch)][$past(paged_idx)] == $past(i_cmd_wdata);
   endproperty
   a_paged_write: assert property (p_paged_write) else $error("paged write lost");

   // Unsupported codes read back as zero
   property p_bad_code_zero;
      @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_req && !i_cmd_write && !code_hit |=> o_rdata == 16'h0000;
   endproperty
   a_bad_code_zero: assert property (p_bad_code_zero) else $error("bad code read not zero");

   // Input at or above the start level opens the window
   property p_input_start;
      @(posedge i_clk) disable iff (!i_nrst)
      vin_fixed >= start_fixed |=> o_input_ok;
   endproperty
   a_input_start: assert property (p_input_start) else $error("input window not opened");

   // Between the two levels the window keeps its state
   property p_input_hold;
      @(posedge i_clk) disable iff (!i_nrst)
      vin_fixed < start_fixed && vin_fixed > stop_fixed |=> o_input_ok == $past(o_input_ok);
   endproperty
   a_input_hold: assert property (p_input_hold) else $error("input window not held");

   // Losing the input window drops every rail
   property p_rail_input_loss;
      @(posedge i_clk) disable iff (!i_nrst)
      !st_reg.input_ok |=> o_rail_on == '0;
   endproperty
   a_rail_input_loss: assert property (p_rail_input_loss) else $error("rail on without input");

   // Undervoltage compare against the fault limit
   property p_uv_compare;
      @(posedge i_clk) disable iff (!i_nrst)
      i_vout_linear[0] < st_reg.paged[0][SLOT_UV_FAULT] |=> o_vout_uv_fault[0];
   endproperty
   a_uv_compare: assert property (p_uv_compare) else $error("undervoltage not flagged");

   // Delay counter counts up only on a millisecond tick
   property p_delay_on_tick;
      @(posedge i_clk) disable iff (!i_nrst)
      st_reg.tick_cnt < 32'(TICK_CYCLES - 1)
      |=> st_reg.delay_cnt[0] == $past(st_reg.delay_cnt[0]) || st_reg.delay_cnt[0] == 16'h0000;
   endproperty
   a_delay_on_tick: assert property (p_delay_on_tick) else $error("delay moved without tick");

   // Tick counter never passes its period
   property p_tick_bound;
      @(posedge i_clk) disable iff (!i_nrst)
      st_reg.tick_cnt < 32'(TICK_CYCLES);
   endproperty
   a_tick_bound: assert property (p_tick_bound) else $error("tick counter out of range");

endmodule : supply_limit_command_bank

// ==== include/supply_limit_pkg.sv ====
package supply_limit_pkg;

   // Number of output channels behind the page selector
   localparam int CHANNELS = 2;
   // Paged and shared register counts
   localparam int PAGED_N = 17;
   localparam int SHARED_N = 7;

   // Page selector code, its reset value and the broadcast page
   localparam logic [7:0] CODE_PAGE = 8'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] PAGE_ALL = 8'hFF;

   // Per-channel codes, highest index first, index 0 last
   localparam logic [PAGED_N-1:0][7:0] PAGED_CODE = {
      8'h60, 8'h54, 8'h53, 8'h51, 8'h50, 8'h4F, 8'h4A, 8'h47, 8'h46,
      8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40, 8'h38, 8'h27};
   // Per-channel reset values, same order
   localparam logic [PAGED_N-1:0][15:0] PAGED_RESET = {
      16'h8000, 16'h00B8, 16'hE580, 16'hEAA8, 16'h00B8, 16'hEB20, 16'hE230, 16'h0000, 16'hE2D0,
      16'h00B8, 16'h0E66, 16'h0ECD, 16'h1133, 16'h00B8, 16'h119A, 16'hAA8F, 16'hAA00};
   // High where the entry is a one-byte action register
   localparam logic [PAGED_N-1:0] PAGED_IS_BYTE = 17'h0_9288;

   // Shared codes, highest index first, index 0 last
   localparam logic [SHARED_N-1:0][7:0] SHARED_CODE = {
      8'h5D, 8'h58, 8'h56, 8'h55, 8'h36, 8'h35, 8'h33};
   localparam logic [SHARED_N-1:0][15:0] SHARED_RESET = {
      16'hD280, 16'hCB26, 16'h0080, 16'hD3E0, 16'hCB00, 16'hCB40, 16'hFB52};
   localparam logic [SHARED_N-1:0] SHARED_IS_BYTE = 7'h10;

   // Slot indices that the block's own logic reads
   localparam int SLOT_OV_FAULT = 2;
   localparam int SLOT_UV_FAULT = 6;
   localparam int SLOT_TURN_ON_DELAY = 16;
   localparam int SHARED_FREQ = 0;
   localparam int SHARED_START = 1;
   localparam int SHARED_STOP = 2;

   // Millisecond tick: time in ns and clock period in ns
   localparam int MS_NS = 1000000;
   localparam int CLK_NS = 10;
   localparam int MS_CYCLES = MS_NS / CLK_NS;

   // Whole block state, registered as one word
   typedef struct packed {
      logic [7:0] page;
      logic [CHANNELS-1:0][PAGED_N-1:0][15:0] paged;
      logic [SHARED_N-1:0][15:0] shared;
      logic [15:0] rdata;
      logic rvalid;
      logic fault;
      logic input_ok;
      logic [31:0] tick_cnt;
      logic [CHANNELS-1:0][15:0] delay_cnt;
      logic [CHANNELS-1:0] rail_on;
      logic [CHANNELS-1:0] en_meta;
      logic [CHANNELS-1:0] en_sync;
      logic [CHANNELS-1:0] ov_flag;
      logic [CHANNELS-1:0] uv_flag;
   } state_t;

endpackage : supply_limit_pkg

// ==== test/pmbus_host_model.sv ====
`timescale 1ns/10ps
// Host side of the command port: one pulse per command, driven on the falling edge
module pmbus_host_model (
   input wire logic i_clk,
   input wire logic [15:0] i_rdata,
   input wire logic i_rvalid,
   input wire logic i_cmd_fault,
   output logic o_cmd_req,
   output logic o_cmd_write,
   output logic [7:0] o_cmd_code,
   output logic [15:0] o_cmd_wdata
);
   // Idle at time zero; request low
   initial begin
      o_cmd_req = 1'b0;
      o_cmd_write = 1'b0;
      o_cmd_code = 8'hFF;
      o_cmd_wdata = 16'hFFFF;
   end
   // Answer is registered on the taking edge itself, so sample at the next falling edge
   task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data,
         output logic [15:0] rd, output logic vld, output logic flt);
      @(negedge i_clk);
      o_cmd_req = 1'b1;
      o_cmd_write = wr;
      o_cmd_code = code;
      o_cmd_wdata = data;
      @(negedge i_clk);
      rd = i_rdata;
      vld = i_rvalid;
      flt = i_cmd_fault;
      o_cmd_req = 1'b0;
      // Released lines show the inverse, so a stale value can never pass for a hit
      o_cmd_code = ~code;
      o_cmd_wdata = ~data;
   endtask : send
endmodule : pmbus_host_model

// ==== test/supply_limit_command_bank_test.sv ====
`timescale 1ns/10ps
module supply_limit_command_bank_test import supply_limit_pkg::*; ;
   // Short tick keeps delay runs to a few cycles
   localparam int TICK = 4;
   logic i_clk;
   logic i_nrst;
   logic [CHANNELS-1:0] i_enable;
   logic [15:0] i_vin_linear;
   logic [CHANNELS-1:0][15:0] i_vout_linear;
   logic cmd_req;
   logic cmd_write;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata;
   logic [15:0] rdata;
   logic rvalid;
   logic cmd_fault;
   logic input_ok;
   logic [CHANNELS-1:0] rail_on;
   logic [CHANNELS-1:0] ov_fault;
   logic [CHANNELS-1:0] uv_fault;
   int failures;
   int samples_checked;
   // Power-on table, code and value side by side
   localparam logic [7:0] DEF_CODE [24] = '{8'h27, 8'h33, 8'h35, 8'h36, 8'h38, 8'h40, 8'h41, 8'h42,
      8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h4A, 8'h4F, 8'h50, 8'h51, 8'h53, 8'h54, 8'h55, 8'h56,
      8'h58, 8'h5D, 8'h60};
   localparam logic [15:0] DEF_VAL [24] = '{16'hAA00, 16'hFB52, 16'hCB40, 16'hCB00, 16'hAA8F,
      16'h119A, 16'h00B8, 16'h1133, 16'h0ECD, 16'h0E66, 16'h00B8, 16'hE2D0, 16'h0000, 16'hE230,
      16'hEB20, 16'h00B8, 16'hEAA8, 16'hE580, 16'h00B8, 16'hD3E0, 16'h0080, 16'hCB26, 16'hD280,
      16'h8000};

   // Free-running 100 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   supply_limit_command_bank #(.TICK_CYCLES(TICK)) dut (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_req(cmd_req), .i_cmd_write(cmd_write),
      .i_cmd_code(cmd_code), .i_cmd_wdata(cmd_wdata), .i_enable(i_enable),
      .i_vin_linear(i_vin_linear), .i_vout_linear(i_vout_linear), .o_rdata(rdata),
      .o_rvalid(rvalid), .o_cmd_fault(cmd_fault), .o_input_ok(input_ok),
      .o_rail_on(rail_on), .o_vout_ov_fault(ov_fault), .o_vout_uv_fault(uv_fault));

   pmbus_host_model host (
      .i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .i_cmd_fault(cmd_fault),
      .o_cmd_req(cmd_req), .o_cmd_write(cmd_write), .o_cmd_code(cmd_code),
      .o_cmd_wdata(cmd_wdata));

   // Verdict and end of run, also reached from a timeout
   task automatic print_verdict();
      if (failures == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   // Single comparison point
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wait_cycles(input int n);
      repeat (n) @(negedge i_clk);
   endtask : wait_cycles

   // Read one code; a supported code answers with valid and no fault
   task automatic rd_check(input logic [7:0] code, input logic [15:0] exp, input string what);
      logic [15:0] d;
      logic v;
      logic f;
      host.send(1'b0, code, 16'h0000, d, v, f);
      check("rvalid", 16'(v), 16'h0001);
      check("cmd_fault", 16'(f), 16'h0000);
      check(what, d, exp);
   endtask : rd_check

   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      logic [15:0] d;
      logic v;
      logic f;
      host.send(1'b1, code, data, d, v, f);
      check("write fault", 16'(f), 16'h0000);
   endtask : wr

   // Bounded wait for the rail pattern; running out ends the run
   task automatic wait_rail(input logic [1:0] exp, input int bound);
      int k;
      k = 0;
      while (rail_on !== exp && k < bound) begin
         @(negedge i_clk);
         k++;
      end
      if (rail_on !== exp) begin
         check("rail_on", 16'(rail_on), 16'(exp));
         print_verdict();
      end
   endtask : wait_rail

   // Every register at its power-on value, channel 0 selected
   task automatic check_defaults();
      for (int k = 0; k < 24; k++) begin
         rd_check(DEF_CODE[k], DEF_VAL[k], "reset value");
      end
      rd_check(8'h00, 16'h0000, "page");
   endtask : check_defaults

   // Channel copies stay apart; a bad page is refused and the old page kept
   task automatic check_pages();
      logic [15:0] d;
      logic v;
      logic f;
      wr(8'h00, 16'h0001);
      wr(8'h27, 16'h1234);
      wr(8'h41, 16'hABCD);
      rd_check(8'h27, 16'h1234, "ch1 slew");
      rd_check(8'h41, 16'h00CD, "ch1 ov action");
      host.send(1'b1, 8'h00, 16'h0005, d, v, f);
      check("bad page fault", 16'(f), 16'h0001);
      rd_check(8'h00, 16'h0001, "page kept");
      wr(8'h33, 16'h5555);
      wr(8'h00, 16'h00FF);
      wr(8'h42, 16'h1111);
      rd_check(8'h42, 16'h1111, "all-page ov warn");
      wr(8'h00, 16'h0001);
      rd_check(8'h42, 16'h1111, "ch1 ov warn");
      wr(8'h00, 16'h0000);
      rd_check(8'h27, 16'hAA00, "ch0 slew");
      rd_check(8'h41, 16'h00B8, "ch0 ov action");
      rd_check(8'h33, 16'h5555, "shared freq");
   endtask : check_pages

   // Unsupported code: read gives zero with fault, write is refused
   task automatic check_bad_code();
      logic [15:0] d;
      logic v;
      logic f;
      host.send(1'b0, 8'h01, 16'h0000, d, v, f);
      check("bad read fault", 16'(f), 16'h0001);
      check("bad read valid", 16'(v), 16'h0001);
      check("bad read data", d, 16'h0000);
      host.send(1'b1, 8'h01, 16'hFFFF, d, v, f);
      check("bad write fault", 16'(f), 16'h0001);
   endtask : check_bad_code

   // Start and stop thresholds with hysteresis between them
   task automatic check_window();
      i_vin_linear = 16'hCB3F;
      wait_cycles(2);
      check("input_ok below start", 16'(input_ok), 16'h0000);
      i_vin_linear = 16'hCB40;
      wait_cycles(2);
      check("input_ok at start", 16'(input_ok), 16'h0001);
      i_vin_linear = 16'hCB20;
      wait_cycles(2);
      check("input_ok held", 16'(input_ok), 16'h0001);
      i_vin_linear = 16'hCB00;
      wait_cycles(2);
      check("input_ok at stop", 16'(input_ok), 16'h0000);
      i_vin_linear = 16'hD200;
      wait_cycles(2);
      check("input_ok other exponent", 16'(input_ok), 16'h0001);
   endtask : check_window

   // Output limits compared as unsigned words, one step past each bound
   task automatic check_limits();
      i_vout_linear = {16'h1000, 16'h119B};
      wait_cycles(2);
      check("ov flags", 16'(ov_fault), 16'h0001);
      check("uv flags", 16'(uv_fault), 16'h0000);
      i_vout_linear = {16'h0E65, 16'h119A};
      wait_cycles(2);
      check("ov at limit", 16'(ov_fault), 16'h0000);
      check("uv below", 16'(uv_fault), 16'h0002);
   endtask : check_limits

   // Channel 1 waits two ticks, channel 0 turns on at once
   task automatic check_turn_on();
      wr(8'h00, 16'h0001);
      wr(8'h60, 16'h0002);
      i_enable = 2'b11;
      wait_cycles(3);
      check("rail zero delay", 16'(rail_on), 16'h0001);
      wait_cycles(2);
      check("rail still waiting", 16'(rail_on), 16'h0001);
      wait_rail(2'b11, 20);
      i_enable = 2'b10;
      wait_cycles(3);
      check("rail after disable", 16'(rail_on), 16'h0002);
      i_vin_linear = 16'h0000;
      wait_cycles(3);
      check("rail after input loss", 16'(rail_on), 16'h0000);
   endtask : check_turn_on

   // Mid-run reset brings back the page and the channel 1 defaults
   task automatic check_reset();
      wr(8'h38, 16'h4321);
      rd_check(8'h38, 16'h4321, "ch1 gain");
      i_nrst = 1'b0;
      wait_cycles(2);
      i_nrst = 1'b1;
      rd_check(8'h00, 16'h0000, "page after reset");
      wr(8'h00, 16'h0001);
      rd_check(8'h38, 16'hAA8F, "ch1 gain after reset");
   endtask : check_reset

   // Main sequence
   initial begin
      failures = 0;
      samples_checked = 0;
      i_nrst = 1'b0;
      i_enable = 2'b00;
      i_vin_linear = 16'h0000;
      i_vout_linear = {16'h1000, 16'h1000};
      repeat (4) @(negedge i_clk);
      i_nrst = 1'b1;
      check_defaults();
      check_pages();
      check_bad_code();
      check_window();
      check_limits();
      check_turn_on();
      check_reset();
      print_verdict();
   end
endmodule : supply_limit_command_bank_test
